/* File: logic/psbr_flag_if.sv */
// carrier between the register core and a bank of self-clearing flags
`timescale 1ns/1ps
interface psbr_flag_if
#(
   parameter int W = 9
);
   logic [W-1:0] evt;
   logic [W-1:0] clr;
   logic         sw_clr;
   logic [W-1:0] flags;

   modport bank (input evt, input clr, input sw_clr, output flags);
   modport user (output evt, output clr, output sw_clr, input flags);
endinterface : psbr_flag_if

/* File: logic/psbr_pkg.sv */
// shared constants for the phy status, bypass and extended control registers
package psbr_pkg;

   // register addresses on the serial management port
   localparam logic [4:0]  REG_GIG_STAT2   = 5'h11;
   localparam logic [4:0]  REG_BYPASS      = 5'h12;
   localparam logic [4:0]  REG_EXT_CTRL    = 5'h16;

   // management frame fields
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
   localparam logic [3:0]  HDR_LAST        = 4'hC;
   localparam logic [3:0]  DATA_LAST       = 4'hF;

   // gigabit status extension two layout
   localparam int          GS_LOCKED       = 15;
   localparam int          GS_LINK         = 12;
   localparam int          GS_FLAG_LO      = 7;

   // bypass control layout, reset value and access masks
   localparam int          BY_TX_DIS       = 15;
   localparam int          BY_TEST_CLK     = 8;
   localparam int          BY_MDIX_OFF     = 7;
   localparam int          BY_PAIR_OFF     = 5;
   localparam int          BY_POL_OFF      = 4;
   localparam int          BY_PD_ADV       = 3;
   localparam int          BY_NP_OFF       = 1;
   localparam int          BY_CLOCK_OUTPUT_PIN       = 0;
   localparam logic [15:0] BY_RESET        = 16'h0088;
   localparam logic [15:0] BY_WMASK        = 16'h81BB;
   localparam logic [15:0] BY_STICKY       = 16'h00BB;

   // extended control and status layout, reset value and access masks
   localparam int          EX_FORCE_LINK   = 15;
   localparam int          EX_JAB_OFF      = 14;
   localparam int          EX_ECHO_OFF     = 13;
   localparam int          EX_SQ_HI        = 11;
   localparam int          EX_SQ_LO        = 10;
   localparam int          EX_STICKY_EN    = 9;
   localparam int          EX_EOF_ERR      = 8;
   localparam int          EX_DISC10       = 7;
   localparam int          EX_LINK10       = 6;
   localparam int          EX_BCAST        = 0;
   localparam logic [15:0] EX_RESET        = 16'h2200;
   localparam logic [15:0] EX_WMASK        = 16'hEE01;
   localparam logic [15:0] EX_STICKY       = 16'hEC01;
   localparam logic [15:0] EX_SUPER        = 16'h0200;

   // squelch selections
   localparam logic [1:0]  SQ_NORMAL       = 2'h0;
   localparam logic [1:0]  SQ_LOW          = 2'h1;
   localparam logic [1:0]  SQ_HIGH         = 2'h2;

   // self-clearing flag vector: 6..0 gigabit, 7 eof, 8 10base-t disconnect
   localparam int          FLAG_W          = 9;
   localparam logic [8:0]  CLR_GIG         = 9'h07F;
   localparam logic [8:0]  CLR_EXT         = 9'h180;

   // strap settle: cycles after reset release before the strap is taken
   localparam logic [1:0]  STRAP_WAIT      = 2'h2;

   // management frame states
   typedef enum logic [4:0]
   {
      PSBR_PRE  = 5'b00001,
      PSBR_HDR  = 5'b00010,
      PSBR_TA   = 5'b00100,
      PSBR_WDAT = 5'b01000,
      PSBR_RDAT = 5'b10000
   } psbr_state_e;

endpackage : psbr_pkg

/* File: logic/psbr_regs.sv */
// per-port status, bypass and extended control registers behind mdio
`timescale 1ns/1ps
// Overview of operation
// - status bit 15 shows live gigabit descrambler lock, not latched
// - status bits 14,13,11..7 are self-clearing gigabit error flags
// - status bit 12 shows live gigabit link, not latched
// - bypass bit 15 set disables the line transmitter
// - sticky bypass bit 7, default 1, stops auto crossover at forced speed
// - sticky bypass bit 5 set stops pair swap correction
// - sticky bypass bit 4 set stops polarity correction
// - sticky bypass bit 3 makes parallel detect honour advertised ability
// - sticky bypass bit 1 hands next-page exchange to management
// - sticky bypass bit 0 enables clock output, default from strap
// - sticky extended bit 15 forces 10base-t link pass
// - sticky extended bit 14 set disables jabber detection
// - sticky extended bit 13, default 1, disables 10base-t echo
// - extended bits 11:10 choose normal, low or high squelch
// - extended bit 9 keeps sticky bits across software reset
// - super-sticky bits always survive software reset
// - extended bit 8 is a self-clearing end-of-frame error flag
// - bit 7 self-clearing 10base-t disconnect, bit 6 live link
// - extended bit 0 broadcasts management writes to every port
// - reads under broadcast return only the addressed port
module psbr_regs
   import psbr_pkg::*;
#(
   parameter int         NUM_PORTS = 8,
   parameter logic [4:0] PORT_BASE = 5'h00
)
(
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // serial management port, mdc sampled as a plain input
   input  wire logic                 mdc,
   input  wire logic                 mdio_i,
   output logic                      mdio_o,
   output logic                      mdio_oe_n,
   input  wire logic                 strap_config_default,
   // per-port software reset pulse
   input  wire logic [NUM_PORTS-1:0] soft_rst,
   // per-port live status from the line logic
   input  wire logic [NUM_PORTS-1:0] gig_descr_locked,
   input  wire logic [NUM_PORTS-1:0] gig_link_up,
   input  wire logic [NUM_PORTS-1:0] link10_up,
   input  wire logic [NUM_PORTS-1:0] speed_forced,
   // per-port one-cycle event pulses
   input  wire logic [NUM_PORTS-1:0] gig_lock_err_evt,
   input  wire logic [NUM_PORTS-1:0] gig_disc_evt,
   input  wire logic [NUM_PORTS-1:0] gig_rx_err_evt,
   input  wire logic [NUM_PORTS-1:0] gig_tx_err_evt,
   input  wire logic [NUM_PORTS-1:0] gig_ssd_err_evt,
   input  wire logic [NUM_PORTS-1:0] gig_esd_err_evt,
   input  wire logic [NUM_PORTS-1:0] gig_cext_err_evt,
   input  wire logic [NUM_PORTS-1:0] eof_err_evt,
   input  wire logic [NUM_PORTS-1:0] link10_disc_evt,
   // per-port controls
   output logic      [NUM_PORTS-1:0] tx_disable,
   output logic      [NUM_PORTS-1:0] tx_test_clk_en,
   output logic      [NUM_PORTS-1:0] mdix_auto_off,
   output logic      [NUM_PORTS-1:0] pair_swap_corr_off,
   output logic      [NUM_PORTS-1:0] polarity_corr_off,
   output logic      [NUM_PORTS-1:0] pd_honour_adv,
   output logic      [NUM_PORTS-1:0] auto_np_off,
   output logic      [NUM_PORTS-1:0] clock_output_pin_en,
   output logic      [NUM_PORTS-1:0] link10_pass,
   output logic      [NUM_PORTS-1:0] jabber_detect_off,
   output logic      [NUM_PORTS-1:0] echo10_off,
   output logic      [2*NUM_PORTS-1:0] squelch_sel
);
   localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

   // assembled read word of one register of one port
   function automatic logic [15:0] rd_word
   (
      input logic [4:0]        ra,
      input logic [15:0]       byp,
      input logic [15:0]       ext,
      input logic [FLAG_W-1:0] fl,
      input logic              locked,
      input logic              glink,
      input logic              l10
   );
      logic [15:0] w;
      w = '0;
      case (ra)
         REG_GIG_STAT2:
         begin
            w[GS_LOCKED]             = locked;
            w[GS_LINK]               = glink;
            w[14:13]                 = fl[6:5];
            w[11:GS_FLAG_LO]         = fl[4:0];
         end
         REG_BYPASS:
            w = byp & BY_WMASK;
         REG_EXT_CTRL:
         begin
            w                        = ext & EX_WMASK;
            w[EX_EOF_ERR]            = fl[7];
            w[EX_DISC10]             = fl[8];
            w[EX_LINK10]             = l10;
         end
         default:
            w = '0;
      endcase
      return w;
   endfunction : rd_word

   // true for the three addresses this block answers
   function automatic logic own_reg(input logic [4:0] ra);
      return (ra == REG_GIG_STAT2) || (ra == REG_BYPASS) ||
             (ra == REG_EXT_CTRL);
   endfunction : own_reg

   logic [2:0]        sync_q;
   logic              mdc_s;
   logic              mdio_s;
   logic              strap_s;
   logic              mdc_d;
   logic              rise;
   psbr_state_e       state;
   logic [5:0]        pre_cnt;
   logic [3:0]        bit_cnt;
   logic [11:0]       hdr;
   logic [12:0]       next_hdr;
   logic [4:0]        next_diff;
   logic              is_read;
   logic              hit;
   logic [PW-1:0]     cur_port;
   logic [4:0]        cur_reg;
   logic [15:0]       shreg;
   logic [15:0]       rd_now;
   logic              rd_load;
   logic              wr_pulse;
   logic [15:0]       wr_data;
   logic [1:0]        strap_cnt;
   logic              strap_load;
   logic              strap_lat;
   logic [15:0]       byp_q [NUM_PORTS];
   logic [15:0]       ext_q [NUM_PORTS];
   logic [FLAG_W-1:0] flags [NUM_PORTS];

   // mdc, mdio and the strap come from outside and are synchronised
   psbr_sync #(.W(3)) u_sync
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .d        ({mdc, mdio_i, strap_config_default}),
      .q        (sync_q)
   );
   assign mdc_s   = sync_q[2];
   assign mdio_s  = sync_q[1];
   assign strap_s = sync_q[0];

   // mdc edge detect on the synchronised copy only
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         mdc_d <= 1'b0;
      else
         mdc_d <= mdc_s;
   end
   assign rise = mdc_s & ~mdc_d;

   // header decode of the bit arriving now
   assign next_hdr  = {hdr, mdio_s};
   assign next_diff = next_hdr[9:5] - PORT_BASE;

   // the snapshot cycle of a read; flags clear in that same cycle
   assign rd_load = rise && (state == PSBR_TA) && (bit_cnt == 4'h1) &&
                    is_read && hit;

   // word of the addressed port and register, taken at the snapshot
   assign rd_now = rd_word(cur_reg, byp_q[cur_port], ext_q[cur_port],
                           flags[cur_port],
                           gig_descr_locked[cur_port],
                           gig_link_up[cur_port], link10_up[cur_port]);

   // management frame receiver and read shifter
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state     <= PSBR_PRE;
         pre_cnt   <= '0;
         bit_cnt   <= '0;
         hdr       <= '0;
         is_read   <= 1'b0;
         hit       <= 1'b0;
         cur_port  <= '0;
         cur_reg   <= '0;
         shreg     <= '0;
         mdio_o    <= 1'b1;
         mdio_oe_n <= 1'b1;
         wr_pulse  <= 1'b0;
         wr_data   <= '0;
      end
      else
      begin
         wr_pulse <= 1'b0;
         if (rise)
         begin
            case (state)
               PSBR_PRE:
               begin
                  // a full preamble then the first start bit opens a frame
                  if (mdio_s)
                     pre_cnt <= (pre_cnt == PREAMBLE_LEN) ? pre_cnt :
                                pre_cnt + 6'h01;
                  else
                  begin
                     if (pre_cnt == PREAMBLE_LEN)
                     begin
                        state   <= PSBR_HDR;
                        bit_cnt <= '0;
                     end
                     pre_cnt <= '0;
                  end
               end
               PSBR_HDR:
               begin
                  hdr     <= next_hdr[11:0];
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == HDR_LAST)
                  begin
                     bit_cnt  <= '0;
                     is_read  <= (next_hdr[11:10] == OP_READ);
                     cur_reg  <= next_hdr[4:0];
                     cur_port <= next_diff[PW-1:0];
                     hit      <= (next_diff < 5'(NUM_PORTS)) &&
                                 own_reg(next_hdr[4:0]);
                     // bad start or opcode drops back to preamble hunt
                     if (next_hdr[12] && (next_hdr[11:10] == OP_READ ||
                                          next_hdr[11:10] == OP_WRITE))
                        state <= PSBR_TA;
                     else
                        state <= PSBR_PRE;
                  end
               end
               PSBR_TA:
               begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'h0 && is_read && hit)
                  begin
                     mdio_o    <= 1'b0;
                     mdio_oe_n <= 1'b0;
                  end
                  if (bit_cnt == 4'h1)
                  begin
                     bit_cnt <= '0;
                     if (is_read && hit)
                     begin
                        // only the addressed port answers a read
                        shreg  <= rd_now;
                        mdio_o <= rd_now[15];
                        state  <= PSBR_RDAT;
                     end
                     else
                        state <= PSBR_WDAT;
                  end
               end
               PSBR_RDAT:
               begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == DATA_LAST)
                  begin
                     mdio_o    <= 1'b1;
                     mdio_oe_n <= 1'b1;
                     state     <= PSBR_PRE;
                  end
                  else
                  begin
                     shreg  <= {shreg[14:0], 1'b0};
                     mdio_o <= shreg[14];
                  end
               end
               PSBR_WDAT:
               begin
                  bit_cnt <= bit_cnt + 4'h1;
                  shreg   <= {shreg[14:0], mdio_s};
                  if (bit_cnt == DATA_LAST)
                  begin
                     wr_data  <= {shreg[14:0], mdio_s};
                     wr_pulse <= !is_read && hit;
                     state    <= PSBR_PRE;
                  end
               end
               default:
                  state <= PSBR_PRE;
            endcase
         end
      end
   end

   // strap is taken once it has passed the synchroniser after release
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strap_cnt <= '0;
         strap_lat <= 1'b0;
      end
      else if (strap_cnt != STRAP_WAIT + 2'h1)
      begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == STRAP_WAIT)
            strap_lat <= strap_s;
      end
   end
   assign strap_load = (strap_cnt == STRAP_WAIT);

   // control registers; software reset beats a write in the same cycle
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            byp_q[p] <= BY_RESET;
            ext_q[p] <= EX_RESET;
         end
      end
      else
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            if (strap_load)
               byp_q[p][BY_CLOCK_OUTPUT_PIN] <= strap_s;
            else if (soft_rst[p])
            begin
               // sticky bits kept only with sticky reset enabled
               if (ext_q[p][EX_STICKY_EN])
               begin
                  byp_q[p] <= (byp_q[p] & BY_STICKY) |
                              (BY_RESET & ~BY_STICKY);
                  ext_q[p] <= ext_q[p];
               end
               else
               begin
                  byp_q[p] <= BY_RESET | {15'h0000, strap_lat};
                  // super-sticky bit survives either way
                  ext_q[p] <= (EX_RESET & ~EX_SUPER) |
                              (ext_q[p] & EX_SUPER);
               end
            end
            else if (wr_pulse &&
                     ((PW'(p) == cur_port) ||
                      ext_q[cur_port][EX_BCAST]))
            begin
               if (cur_reg == REG_BYPASS)
                  byp_q[p] <= wr_data & BY_WMASK;
               if (cur_reg == REG_EXT_CTRL)
                  ext_q[p] <= wr_data & EX_WMASK;
            end
         end
      end
   end

   // per-port flag banks and control outputs
   generate
      for (genvar g = 0; g < NUM_PORTS; g++)
      begin : g_port
         psbr_flag_if #(.W(FLAG_W)) fif ();

         assign fif.evt    = {link10_disc_evt[g], eof_err_evt[g],
                              gig_lock_err_evt[g], gig_disc_evt[g],
                              gig_rx_err_evt[g], gig_tx_err_evt[g],
                              gig_ssd_err_evt[g], gig_esd_err_evt[g],
                              gig_cext_err_evt[g]};
         // read clears only the flags of the register just read
         assign fif.clr    = (rd_load && cur_port == PW'(g)) ?
                             ((cur_reg == REG_GIG_STAT2) ? CLR_GIG :
                              (cur_reg == REG_EXT_CTRL) ? CLR_EXT :
                              '0) : '0;
         assign fif.sw_clr = soft_rst[g];
         assign flags[g]   = fif.flags;

         psbr_sc_flags u_flags
         (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .fl       (fif)
         );

         // gated controls are registered so they stay glitch free
         always_ff @(posedge core_clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               mdix_auto_off[g] <= 1'b0;
               link10_pass[g]   <= 1'b0;
            end
            else
            begin
               mdix_auto_off[g] <= byp_q[g][BY_MDIX_OFF] &
                                   speed_forced[g];
               link10_pass[g]   <= ext_q[g][EX_FORCE_LINK] |
                                   link10_up[g];
            end
         end

         assign tx_disable[g]          = byp_q[g][BY_TX_DIS];
         assign tx_test_clk_en[g]      = byp_q[g][BY_TEST_CLK];
         assign pair_swap_corr_off[g]  = byp_q[g][BY_PAIR_OFF];
         assign polarity_corr_off[g]   = byp_q[g][BY_POL_OFF];
         assign pd_honour_adv[g]       = byp_q[g][BY_PD_ADV];
         assign auto_np_off[g]         = byp_q[g][BY_NP_OFF];
         assign clock_output_pin_en[g] = byp_q[g][BY_CLOCK_OUTPUT_PIN];
         assign jabber_detect_off[g]   = ext_q[g][EX_JAB_OFF];
         assign echo10_off[g]          = ext_q[g][EX_ECHO_OFF];
         assign squelch_sel[2*g+1 -: 2] =
            ext_q[g][EX_SQ_HI:EX_SQ_LO];
      end
   endgenerate

endmodule : psbr_regs

/* File: logic/psbr_sc_flags.sv */
// bank of self-clearing event flags, cleared by a read
`timescale 1ns/1ps
module psbr_sc_flags
(
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   psbr_flag_if.bank   fl
);
   // a new event in the clearing cycle survives: set wins
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         fl.flags <= '0;
      else if (fl.sw_clr)
         fl.flags <= fl.evt;
      else
         fl.flags <= (fl.flags & ~fl.clr) | fl.evt;
   end
endmodule : psbr_sc_flags

/* File: logic/psbr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psbr_sync
#(
   parameter int W = 3
)
(
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : psbr_sync

/* File: test/psbr_regs_chk.sv */
// concurrent checks on the register block pins
`timescale 1ns/1ps
module psbr_regs_chk
#(
   parameter int NUM_PORTS = 8
)
(
   input wire logic                   core_clk,
   input wire logic                   sys_rst,
   input wire logic                   mdc,
   input wire logic                   mdio_o,
   input wire logic                   mdio_oe_n,
   input wire logic [NUM_PORTS-1:0]   soft_rst,
   input wire logic [NUM_PORTS-1:0]   speed_forced,
   input wire logic [NUM_PORTS-1:0]   link10_up,
   input wire logic [NUM_PORTS-1:0]   mdix_auto_off,
   input wire logic [NUM_PORTS-1:0]   link10_pass,
   input wire logic [NUM_PORTS-1:0]   tx_disable,
   input wire logic [2*NUM_PORTS-1:0] squelch_sel
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // a write lands a few cycles after an mdc rise, six idle cycles settle it
   sequence s_idle; !mdc [*6] ##0 (soft_rst == '0); endsequence
   sequence s_drive; !mdio_oe_n [*8]; endsequence
   property p_idle; s_idle |=> $stable({tx_disable, squelch_sel}); endproperty
   property p_rst; $past(sys_rst) |-> !(|{tx_disable, squelch_sel}); endproperty
   property p_live; $past(sys_rst) |-> !(|{mdix_auto_off, link10_pass});
   endproperty
   property p_mdix;
      !$past(sys_rst) |-> (mdix_auto_off & ~$past(speed_forced)) == '0;
   endproperty
   property p_l10;
      !$past(sys_rst) |-> ($past(link10_up) & ~link10_pass) == '0;
   endproperty
   property p_pin; $changed(mdio_oe_n) |-> $past(mdc, 2) || $past(mdc, 3);
   endproperty
   property p_ta; $fell(mdio_oe_n) |-> !mdio_o ##1 s_drive; endproperty
   property p_srst; |soft_rst |=> (tx_disable & $past(soft_rst)) == '0;
   endproperty
   a_idle: assert property (p_idle) else $error("control moved idle");
   a_rst: assert property (p_rst) else $error("bad reset value");
   a_live: assert property (p_live) else $error("bad reset live");
   a_mdix: assert property (p_mdix) else $error("crossover off");
   a_l10: assert property (p_l10) else $error("link pass lost");
   a_pin: assert property (p_pin) else $error("pin moved late");
   a_ta: assert property (p_ta) else $error("bad turnaround");
   a_srst: assert property (p_srst) else $error("tx kept");
endmodule : psbr_regs_chk

bind psbr_regs psbr_regs_chk #(.NUM_PORTS(NUM_PORTS)) i_chk
(
   .core_clk(core_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_o(mdio_o),
   .mdio_oe_n(mdio_oe_n), .soft_rst(soft_rst), .speed_forced(speed_forced),
   .link10_up(link10_up), .mdix_auto_off(mdix_auto_off),
   .link10_pass(link10_pass), .tx_disable(tx_disable),
   .squelch_sel(squelch_sel)
);

/* File: test/psbr_smc.sv */
// management controller model: drives mdc and mdio frames
`timescale 1ns/1ps
module psbr_smc
   import psbr_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic md_i,
   output logic      mdc = 1'b0,
   output logic      md_do = 1'b1,
   output logic      md_oe = 1'b0
);
   int hp = 4; // mdc half period in core cycles, kept above the 2 needed
   // one frame with its own preamble, msb first; mdc stands low after it
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--)
      begin
         mdc = 1'b0;
         md_do = f[i];
         md_oe = op == OP_WRITE || i > 17; // let go for turnaround and data
         repeat (hp) @(negedge core_clk);
         rd = {rd[14:0], md_i}; // last sixteen samples are the data slots
         mdc = 1'b1;
         repeat (hp) @(negedge core_clk);
      end
      mdc = 1'b0;
      md_oe = 1'b0;
      repeat (2 * hp) @(negedge core_clk);
   endtask : xfer
endmodule : psbr_smc

/* File: test/tb_psbr_regs.sv */
// bench for the status, bypass and extended control registers
`timescale 1ns/1ps
module tb_psbr_regs;
   import psbr_pkg::*;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [1:0]  srst = 2'h0, lock = 2'h0, glink = 2'h0, l10 = 2'h0, sf = 2'h1;
   logic [1:0]  ev [9] = '{default: 2'h0};
   logic [1:0]  txd, mdix, l10p, tce, psw, pol, pda, anp, cko, jab, eco;
   logic [3:0]  sq;
   logic        mdc, mdio_o, oe_n, mdio_i, s_do, s_oe;
   logic [15:0] v;
   int          bad_count = 0, comparisons = 0, cyc = 0;
   // wire level: pull-up when neither end drives
   assign mdio_i = !oe_n ? mdio_o : (s_oe ? s_do : 1'b1);
   initial forever #2 core_clk = ~core_clk;
   psbr_regs #(.NUM_PORTS(2)) i_dut
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_i(mdio_i),
      .mdio_o(mdio_o), .mdio_oe_n(oe_n), .strap_config_default(1'b1),
      .soft_rst(srst), .gig_descr_locked(lock), .gig_link_up(glink),
      .link10_up(l10), .speed_forced(sf), .gig_lock_err_evt(ev[0]),
      .gig_disc_evt(ev[1]), .gig_rx_err_evt(ev[2]), .gig_tx_err_evt(ev[3]),
      .gig_ssd_err_evt(ev[4]), .gig_esd_err_evt(ev[5]),
      .gig_cext_err_evt(ev[6]), .eof_err_evt(ev[7]), .link10_disc_evt(ev[8]),
      .tx_disable(txd), .tx_test_clk_en(tce), .mdix_auto_off(mdix),
      .pair_swap_corr_off(psw), .polarity_corr_off(pol),
      .pd_honour_adv(pda), .auto_np_off(anp), .clock_output_pin_en(cko),
      .link10_pass(l10p), .jabber_detect_off(jab), .echo10_off(eco),
      .squelch_sel(sq)
   );
   psbr_smc i_smc
   (
      .core_clk(core_clk), .md_i(mdio_i), .mdc(mdc), .md_do(s_do),
      .md_oe(s_oe)
   );
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk
   // one frame; a read compares the word against d
   task automatic mf(input logic [1:0] o, input logic [4:0] pa, ra,
                     input logic [15:0] d);
      i_smc.xfer(o, pa, ra, d, v);
      if (o == OP_READ)
         chk(v, d);
   endtask : mf
   task automatic sr;
      srst = 2'h1;
      @(negedge core_clk);
      srst = 2'h0;
   endtask : sr
   task automatic t_reset;
      mf(OP_READ, 5'h0, REG_BYPASS, 16'h0089);
      mf(OP_READ, 5'h1, REG_EXT_CTRL, 16'h2200);
      chk({14'h0, mdix}, 16'h0001);
   endtask : t_reset
   task automatic t_status;
      lock = 2'h1;
      glink = 2'h1;
      l10 = 2'h1;
      foreach (ev[e]) ev[e] = 2'h1;
      @(negedge core_clk);
      foreach (ev[e]) ev[e] = 2'h0;
      mf(OP_READ, 5'h0, REG_GIG_STAT2, 16'hFF80);
      mf(OP_READ, 5'h0, REG_GIG_STAT2, 16'h9000);
      mf(OP_READ, 5'h1, REG_GIG_STAT2, 16'h0000);
      mf(OP_READ, 5'h0, REG_EXT_CTRL, 16'h23C0);
      mf(OP_READ, 5'h0, REG_EXT_CTRL, 16'h2240);
      chk({14'h0, l10p}, 16'h0001);
   endtask : t_status
   // slow controller, read-only and unmapped places, the three squelch selections
   task automatic t_write;
      i_smc.hp = 6;
      mf(OP_WRITE, 5'h0, REG_BYPASS, 16'hFFFF);
      mf(OP_READ, 5'h0, REG_BYPASS, 16'h81BB);
      chk({14'h0, txd}, 16'h0001);
      chk({tce, psw, pol, pda, anp, cko, jab, eco}, 16'h5773);
      mf(OP_WRITE, 5'h0, REG_GIG_STAT2, 16'h0000);
      mf(OP_READ, 5'h0, REG_GIG_STAT2, 16'h9000);
      mf(OP_READ, 5'h0, 5'h13, 16'hFFFF);
      mf(OP_READ, 5'h5, REG_BYPASS, 16'hFFFF);
      i_smc.hp = 4;
      for (int s = 0; s < 3; s++)
      begin
         mf(OP_WRITE, 5'h0, REG_EXT_CTRL, 16'h6200 | 16'(s << 10));
         chk({12'h0, sq}, 16'(s));
      end
   endtask : t_write
   task automatic t_soft;
      sr;
      mf(OP_READ, 5'h0, REG_BYPASS, 16'h00BB);
      mf(OP_READ, 5'h0, REG_EXT_CTRL, 16'h6A40);
      chk({14'h0, jab}, 16'h0001);
      mf(OP_WRITE, 5'h0, REG_EXT_CTRL, 16'h0000);
      sr;
      mf(OP_READ, 5'h0, REG_BYPASS, 16'h0089);
      mf(OP_READ, 5'h0, REG_EXT_CTRL, 16'h2040);
   endtask : t_soft
   task automatic t_bcast;
      mf(OP_WRITE, 5'h0, REG_EXT_CTRL, 16'h2201);
      mf(OP_WRITE, 5'h0, REG_BYPASS, 16'h8000);
      mf(OP_READ, 5'h1, REG_BYPASS, 16'h8000);
      mf(OP_READ, 5'h1, REG_GIG_STAT2, 16'h0000);
      mf(OP_WRITE, 5'h0, REG_EXT_CTRL, 16'h2200);
      mf(OP_WRITE, 5'h0, REG_BYPASS, 16'h0000);
      chk({14'h0, txd}, 16'h0002);
   endtask : t_bcast
   task automatic results;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   initial
   begin
      repeat (10) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge core_clk);
      t_reset;
      t_status;
      t_write;
      t_soft;
      t_bcast;
      results;
   end
   // a full run needs about 15600 cycles
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         results;
      end
   end
endmodule : tb_psbr_regs
